/* hdl/pmirq_top.sv */
// pmirq_top.sv: power mode control and interrupt summary, Avalon-MM slave.
// assumes: sys_clk 10 MHz, rst_b covers every reset form, external
// interrupt lines are asynchronous pins.
//
// The implementer's own choice: the Avalon-MM slave port.
`timescale 1ns/1ps
`include "pmirq_defs.svh"
module pmirq_top #(
    parameter int NSRC = 8,
    parameter int NEXT = 4,
    parameter int WARMUP_CYC = `PMIRQ_WARMUP_CYC
) (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic [`PMIRQ_ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic [1:0] avs_response,
    input wire logic [NSRC-1:0] mod0_flags,
    input wire logic [NSRC-1:0] mod0_enables,
    input wire logic [NSRC-1:0] spr_flags,
    input wire logic [NSRC-1:0] spr_enables,
    input wire logic [NEXT-1:0] ext_irq_pins,
    input wire logic [NEXT-1:0] ext_irq_enables,
    output logic ip_hold,
    output logic module_sel_en,
    output logic low_power,
    output logic clock_gate_en,
    output logic irq
);
    import pmirq_pkg::*;

    // ------------------------------------------------------------------
    // overview
    // ------------------------------------------------------------------
    // software sets the stop or idle bit of clock control; the mode
    // machine follows on the next edge and drives the halt outputs.
    // stop wins over idle when both bits are written together, since
    // stop is the deeper state and its exit path is the longer one.
    // stop is left only through an enabled external pin or a reset,
    // and passes a warm-up count before execution resumes.
    // idle is left by an enabled pin or any pending identified
    // interrupt, straight back to run with no warm-up count.
    // the stop and idle bits are never cleared by software; a write
    // of zero leaves them alone, only the mode machine or a reset drops them.
    // mode changes are logged as sticky events behind a mask, so
    // firmware can see that a low-power period really took place.

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    // all state of this module lives in one record:
    //   stop, idle   - the two software-set mode request bits
    //   mode         - one-hot power mode of the machine
    //   warm_cnt     - cycles left in the warm-up after stop
    //   ev_stat/mask - sticky mode events and their enables
    //   ack, rdata   - bus answer flag and registered read data
    //   resp         - registered bus response code
    typedef struct packed {
        logic stop;
        logic idle;
        pmirq_mode_t mode;
        logic [15:0] warm_cnt;
        logic [`PMIRQ_EV_W-1:0] ev_stat;
        logic [`PMIRQ_EV_W-1:0] ev_mask;
        logic ack;
        logic [31:0] rdata;
        logic [1:0] resp;
    } pmirq_top_st_t;

    pmirq_top_st_t st_q;
    pmirq_top_st_t st_d;

    logic [NEXT-1:0] ext_sync;
    logic [7:0] ident;
    logic wake;
    logic sum_pend;
    logic [3:0] idx;
    logic hit;
    logic [`PMIRQ_EV_W-1:0] ev_set;

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------

    // register index from a word-aligned byte address
    function automatic logic [3:0] word_idx(
        input logic [`PMIRQ_ADDR_W-1:0] a
    );
        word_idx = a[5:2];
    endfunction : word_idx

    // true when the index is a mapped register
    function automatic logic mapped(input logic [3:0] i);
        mapped = (i == `PMIRQ_IDX_CLKCTL) || (i == `PMIRQ_IDX_IRQID) ||
                 (i == `PMIRQ_IDX_EVSTAT) || (i == `PMIRQ_IDX_EVMASK) ||
                 (i == `PMIRQ_IDX_MODE);
    endfunction : mapped

    // clock control read value with fixed reserved fields
    function automatic logic [7:0] clkctl_val(input logic idle_b,
                                             input logic stop_b);
        logic [7:0] v;
        v = `PMIRQ_CLKCTL_RSVD_ONES;
        v[`PMIRQ_BIT_IDLE] = idle_b;
        v[`PMIRQ_BIT_STOP] = stop_b;
        clkctl_val = v;
    endfunction : clkctl_val

    // ------------------------------------------------------------------
    // submodules
    // ------------------------------------------------------------------

    // the pins are asynchronous, so each passes three flip-flops and
    // only a level seen twice in a row counts; a short glitch on a
    // pin therefore cannot wake the block from stop by itself.
    // the price is about four cycles of wake latency, which comes before
    // the warm-up count after stop and is harmless for idle.
    // external interrupt pins into the clock domain
    pmirq_sync #(
        .W(NEXT)
    ) u_sync (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .d(ext_irq_pins),
        .q(ext_sync)
    );

    // identification register contents
    pmirq_summary #(
        .NSRC(NSRC)
    ) u_summary (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .mod0_flags(mod0_flags),
        .mod0_enables(mod0_enables),
        .spr_flags(spr_flags),
        .spr_enables(spr_enables),
        .ident(ident)
    );

    // ------------------------------------------------------------------
    // wake sources and bus decode
    // ------------------------------------------------------------------
    assign wake = |(ext_sync & ext_irq_enables);
    assign sum_pend = ident[`PMIRQ_BIT_SUMMARY] | ident[`PMIRQ_BIT_MOD0];
    assign idx = word_idx(avs_address);
    assign hit = mapped(idx);

    // next state: bus access, mode machine, events
    always_comb begin
        st_d = st_q;
        ev_set = '0;
        st_d.ack = 1'b0;

        // bus: one wait cycle, answer on the second cycle of the request.
        // read data are captured on the first edge and stand in the
        // answer cycle, so the master always sees settled data.
        // ack lasts one cycle only; a strobe still held after the
        // answer edge is taken as a fresh request, never a repeat
        // of the old one, and again costs exactly one wait cycle.
        // bus: one wait cycle, answer on the second cycle of the request
        if ((avs_read || avs_write) && !st_q.ack) begin
            st_d.ack = 1'b1;
            st_d.resp = hit ? 2'h0 : 2'h2;
            st_d.rdata = 32'h0000_0000;
            if (avs_read) begin
                case (idx)
                    `PMIRQ_IDX_CLKCTL: begin
                        st_d.rdata[7:0] = clkctl_val(st_q.idle, st_q.stop);
                    end
                    `PMIRQ_IDX_IRQID: begin
                        st_d.rdata[7:0] = ident;
                    end
                    `PMIRQ_IDX_EVSTAT: begin
                        st_d.rdata[`PMIRQ_EV_W-1:0] = st_q.ev_stat;
                    end
                    `PMIRQ_IDX_EVMASK: begin
                        st_d.rdata[`PMIRQ_EV_W-1:0] = st_q.ev_mask;
                    end
                    `PMIRQ_IDX_MODE: begin
                        st_d.rdata[3:0] = st_q.mode;
                    end
                    default: begin
                        st_d.rdata = 32'h0000_0000;
                    end
                endcase
            end
        end

        // write effects, taken at the edge that ends the answer cycle
        if (avs_write && st_q.ack && avs_byteenable[0]) begin
            case (idx)
                `PMIRQ_IDX_CLKCTL: begin
                    if (avs_writedata[`PMIRQ_BIT_STOP]) begin
                        st_d.stop = 1'b1;
                    end
                    if (avs_writedata[`PMIRQ_BIT_IDLE]) begin
                        st_d.idle = 1'b1;
                    end
                end
                `PMIRQ_IDX_EVSTAT: begin
                    st_d.ev_stat = st_q.ev_stat &
                                   ~avs_writedata[`PMIRQ_EV_W-1:0];
                end
                `PMIRQ_IDX_EVMASK: begin
                    st_d.ev_mask = avs_writedata[`PMIRQ_EV_W-1:0];
                end
                default: begin
                    st_d.ev_mask = st_q.ev_mask;
                end
            endcase
        end

        // mode machine.
        // run looks at the request bits registered on the previous
        // edge, so a write that sets a bit takes effect one cycle
        // after the bus answer.
        // idle keeps clocks running; any wake cause returns to run on
        // the next edge and clears the idle bit in the same step.
        // stop waits for an enabled pin only; pending identified
        // interrupts do not end stop, matching the pin-only wake.
        // warm counts down from the warm-up figure and logs the stop
        // exit event when it reaches run.
        case (st_q.mode)
            PMIRQ_RUN: begin
                if (st_q.stop) begin
                    st_d.mode = PMIRQ_STOP;
                    ev_set[`PMIRQ_EV_STOP_ENTER] = 1'b1;
                end else if (st_q.idle) begin
                    st_d.mode = PMIRQ_IDLE;
                    ev_set[`PMIRQ_EV_IDLE_ENTER] = 1'b1;
                end
            end
            PMIRQ_IDLE: begin
                if (wake || sum_pend) begin
                    st_d.idle = 1'b0;
                    st_d.mode = PMIRQ_RUN;
                    ev_set[`PMIRQ_EV_IDLE_EXIT] = 1'b1;
                end
            end
            PMIRQ_STOP: begin
                if (wake) begin
                    st_d.stop = 1'b0;
                    st_d.mode = PMIRQ_WARM;
                    st_d.warm_cnt = 16'(WARMUP_CYC);
                end
            end
            PMIRQ_WARM: begin
                if (st_q.warm_cnt <= 16'h0001) begin
                    st_d.mode = PMIRQ_RUN;
                    st_d.warm_cnt = 16'h0000;
                    ev_set[`PMIRQ_EV_STOP_EXIT] = 1'b1;
                end else begin
                    st_d.warm_cnt = st_q.warm_cnt - 16'h0001;
                end
            end
            default: begin
                st_d.mode = PMIRQ_RUN;
            end
        endcase

        // sticky events: set wins over a clear in the same cycle.
        // a clear that meets a new event would otherwise lose it, and
        // firmware could miss the only trace of a short idle period.
        st_d.ev_stat = st_d.ev_stat | ev_set;
    end

    // state register; every reset form restores clock control
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            st_q.stop <= 1'b0;
            st_q.idle <= 1'b0;
            st_q.mode <= PMIRQ_RUN;
            st_q.warm_cnt <= 16'h0000;
            st_q.ev_stat <= '0;
            st_q.ev_mask <= '0;
            st_q.ack <= 1'b0;
            st_q.rdata <= 32'h0000_0000;
            st_q.resp <= 2'h0;
        end else begin
            st_q <= st_d;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    // every mode output is a plain decode of the registered mode, so
    // all of them change on the same edge and none can glitch apart.
    // ip_hold covers warm-up too: execution must not resume before
    // the count ends. clock_gate_en is for stop alone, since idle
    // keeps the clocks running and needs no warm-up on exit.
    // waitrequest is the one combinational handshake output; it rises
    // with the strobe and falls in the cycle after the request.
    assign avs_waitrequest = (avs_read || avs_write) && !st_q.ack;
    assign avs_readdata = st_q.rdata;
    assign avs_response = st_q.resp;
    assign ip_hold = st_q.mode != PMIRQ_RUN;
    assign module_sel_en = st_q.mode == PMIRQ_RUN;
    assign low_power = st_q.mode != PMIRQ_RUN;
    assign clock_gate_en = st_q.mode == PMIRQ_STOP;
    assign irq = |(st_q.ev_stat & st_q.ev_mask);
endmodule : pmirq_top

/* hdl/pmirq_defs.svh */
// pmirq_defs.svh: offsets, field positions, reset values and counts for the
// power mode and interrupt summary block.
// assumes: included by bare name from design files; definitions only.
`ifndef PMIRQ_DEFS_SVH
`define PMIRQ_DEFS_SVH

// ----------------------------------------------------------------------
// register indices and address width
// ----------------------------------------------------------------------
`define PMIRQ_IDX_CLKCTL 4'hE
`define PMIRQ_IDX_IRQID 4'hB
`define PMIRQ_IDX_EVSTAT 4'h1
`define PMIRQ_IDX_EVMASK 4'h2
`define PMIRQ_IDX_MODE 4'h3
`define PMIRQ_ADDR_W 6

// ----------------------------------------------------------------------
// clock control and identification fields, clock control reset value
// ----------------------------------------------------------------------
`define PMIRQ_CLKCTL_RST 8'h60
`define PMIRQ_CLKCTL_RSVD_ONES 8'h60
`define PMIRQ_BIT_STOP 4
`define PMIRQ_BIT_IDLE 7
`define PMIRQ_BIT_SUMMARY 7
`define PMIRQ_BIT_MOD0 0

// ----------------------------------------------------------------------
// event status bits
// ----------------------------------------------------------------------
`define PMIRQ_EV_STOP_ENTER 0
`define PMIRQ_EV_STOP_EXIT 1
`define PMIRQ_EV_IDLE_ENTER 2
`define PMIRQ_EV_IDLE_EXIT 3
`define PMIRQ_EV_W 4

// ----------------------------------------------------------------------
// timing: stop exit warm-up time in ns, cycles at 100 ns per cycle
// ----------------------------------------------------------------------
`define PMIRQ_CLK_PERIOD_NS 100
`define PMIRQ_WARMUP_NS 1600
`define PMIRQ_WARMUP_CYC \
    ((`PMIRQ_WARMUP_NS + `PMIRQ_CLK_PERIOD_NS - 1) / `PMIRQ_CLK_PERIOD_NS)

`endif

/* hdl/pmirq_pkg.sv */
// pmirq_pkg.sv: types of the power mode and interrupt summary block.
// assumes: compiled before every module of the block.
package pmirq_pkg;

    // ------------------------------------------------------------------
    // power mode state, one-hot
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        PMIRQ_RUN = 4'h1,
        PMIRQ_IDLE = 4'h2,
        PMIRQ_STOP = 4'h4,
        PMIRQ_WARM = 4'h8
    } pmirq_mode_t;

endpackage : pmirq_pkg

/* hdl/pmirq_sync.sv */
// pmirq_sync.sv: three-stage synchroniser with agreement filter.
// assumes: d arrives from outside the sys_clk domain.
`timescale 1ns/1ps
module pmirq_sync #(
    parameter int W = 1
) (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] q;
    } pmirq_sync_st_t;

    pmirq_sync_st_t st_q;
    pmirq_sync_st_t st_d;

    // shift chain; output moves only where stages two and three agree
    always_comb begin
        st_d = st_q;
        st_d.s1 = d;
        st_d.s2 = st_q.s1;
        st_d.s3 = st_q.s2;
        st_d.q = (st_q.s2 & st_q.s3) | (st_q.q & (st_q.s2 | st_q.s3));
    end

    // state register
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign q = st_q.q;
endmodule : pmirq_sync

/* hdl/pmirq_summary.sv */
// pmirq_summary.sv: interrupt identification summary from flags and enables.
// assumes: flag and enable vectors come from sys_clk logic.
`timescale 1ns/1ps
`include "pmirq_defs.svh"
module pmirq_summary #(
    parameter int NSRC = 8
) (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic [NSRC-1:0] mod0_flags,
    input wire logic [NSRC-1:0] mod0_enables,
    input wire logic [NSRC-1:0] spr_flags,
    input wire logic [NSRC-1:0] spr_enables,
    output logic [7:0] ident
);
    typedef struct packed {
        logic [7:0] ident;
    } pmirq_sum_st_t;

    pmirq_sum_st_t st_q;
    pmirq_sum_st_t st_d;

    // a bit stands only while some flag and its own enable are both set
    always_comb begin
        st_d = st_q;
        st_d.ident = 8'h00;
        st_d.ident[`PMIRQ_BIT_MOD0] = |(mod0_flags & mod0_enables);
        st_d.ident[`PMIRQ_BIT_SUMMARY] = |(spr_flags & spr_enables);
    end

    // registered identification value
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign ident = st_q.ident;
endmodule : pmirq_summary

/* test/pmirq_checker.sv */
// pmirq_checker.sv: port-level assertions for the power mode block.
// assumes: bound into pmirq_top; transfers end when waitrequest is low.
`timescale 1ns/1ps
`include "pmirq_defs.svh"
module pmirq_checker #(
    parameter int NSRC = 8,
    parameter int NEXT = 4,
    parameter int WARMUP_CYC = 16
) (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic [`PMIRQ_ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic [NSRC-1:0] mod0_flags,
    input wire logic [NSRC-1:0] mod0_enables,
    input wire logic [NSRC-1:0] spr_flags,
    input wire logic [NSRC-1:0] spr_enables,
    input wire logic [NEXT-1:0] ext_irq_pins,
    input wire logic [NEXT-1:0] ext_irq_enables,
    input wire logic ip_hold,
    input wire logic module_sel_en,
    input wire logic low_power,
    input wire logic clock_gate_en
);
    // ------------------------------------------------------------------
    // helper state: tracks idle entered straight from run
    // ------------------------------------------------------------------
    localparam int WARM_MAX = WARMUP_CYC + 3;
    typedef struct packed {
        logic sel;
        logic idle;
    } pmirq_chk_t;
    pmirq_chk_t st_q;
    pmirq_chk_t st_d;
    logic rd_ck;
    logic rd_id;
    logic wr_ck;
    logic wake;
    // accepted accesses and pending wake causes
    assign rd_ck = avs_read && !avs_waitrequest && avs_address == 6'h38;
    assign rd_id = avs_read && !avs_waitrequest && avs_address == 6'h2C;
    assign wr_ck = avs_write && !avs_waitrequest && avs_byteenable[0]
        && avs_address == 6'h38;
    assign wake = (|(spr_flags & spr_enables))
        || (|(ext_irq_pins & ext_irq_enables));
    // idle means hold without gate, entered from run
    always_comb begin
        st_d = st_q;
        st_d.sel = module_sel_en;
        st_d.idle = ip_hold && !clock_gate_en && (st_q.idle || st_q.sel);
    end
    // register the helper state
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            st_q <= 2'h2;
        end else begin
            st_q <= st_d;
        end
    end
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_b);
    a_ident_zeros: assert property (rd_id |-> avs_readdata[6:2] == 5'h00)
        else $error("identification reserved bits not zero");
    a_summary_bit: assert property (rd_id |-> avs_readdata[7] ==
        $past(|(spr_flags & spr_enables), 2))
        else $error("summary bit disagrees with flags and enables");
    a_mod0_bit: assert property (rd_id |-> avs_readdata[0] ==
        $past(|(mod0_flags & mod0_enables), 2))
        else $error("module zero bit disagrees with flags and enables");
    a_ctl_fixed: assert property (rd_ck |-> avs_readdata[6:5] == 2'h3
        && avs_readdata[3:0] == 4'h0)
        else $error("clock control fixed bits wrong");
    a_stop_enter: assert property (wr_ck && avs_writedata[4]
        |-> ##[1:3] (clock_gate_en && ip_hold))
        else $error("stop not entered after write");
    a_idle_enter: assert property (wr_ck && avs_writedata[7]
        && !avs_writedata[4] && !wake |-> ##[1:3] (ip_hold && !module_sel_en))
        else $error("idle not entered after write");
    a_stop_halts: assert property (clock_gate_en |-> ip_hold && low_power
        && !module_sel_en)
        else $error("stop without halt");
    a_idle_wake: assert property (st_q.idle && wake
        |-> ##[1:6] module_sel_en)
        else $error("idle exit too slow");
    a_stop_leave: assert property (clock_gate_en
        && (|(ext_irq_pins & ext_irq_enables)) |-> ##[1:8] !clock_gate_en)
        else $error("stop not left on enabled pin");
    a_warm_end: assert property ($fell(clock_gate_en)
        |-> ##[1:WARM_MAX] module_sel_en)
        else $error("run not resumed after warm-up");
endmodule : pmirq_checker

bind pmirq_top pmirq_checker #(
    .NSRC(NSRC),
    .NEXT(NEXT),
    .WARMUP_CYC(WARMUP_CYC)
) u_pmirq_checker (
    .sys_clk, .rst_b, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .mod0_flags,
    .mod0_enables, .spr_flags, .spr_enables, .ext_irq_pins,
    .ext_irq_enables, .ip_hold, .module_sel_en, .low_power, .clock_gate_en
);

/* test/tb_power_mode_and_irq_summary.sv */
// tb_power_mode_and_irq_summary.sv: self-checking bench for pmirq_top.
// assumes: design, package and checker compiled first.
`timescale 1ns/1ps
module tb_power_mode_and_irq_summary;
    logic sys_clk, rst_b, rd, wr, wq, wait_req, hold, sel, lp, gate, irq;
    logic [5:0] adr;
    logic [3:0] be, xp, xe;
    logic [31:0] wdat, rdat, got;
    logic [1:0] resp, rsp;
    logic [7:0] mf, me, sf, se;
    int err_total = 0;
    int n_checks = 0;
    int cyc = 0;
    pmirq_top #(.WARMUP_CYC(2)) dut (.sys_clk, .rst_b, .avs_address(adr),
        .avs_read(rd), .avs_write(wr), .avs_writedata(wdat),
        .avs_byteenable(be), .avs_readdata(rdat), .avs_waitrequest(wait_req),
        .avs_response(resp), .mod0_flags(mf), .mod0_enables(me),
        .spr_flags(sf), .spr_enables(se), .ext_irq_pins(xp),
        .ext_irq_enables(xe), .ip_hold(hold), .module_sel_en(sel),
        .low_power(lp), .clock_gate_en(gate), .irq(irq));
    // ------------------------------------------------------------------
    // clock, timeout and shared tasks
    // ------------------------------------------------------------------
    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end
    // cut a hang short
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            end_of_test();
        end
    end
    task automatic end_of_test;
        if (err_total == 0 && n_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : end_of_test
    task automatic chk(input logic [31:0] seen, input logic [31:0] want);
        n_checks++;
        if (seen !== want) begin
            err_total++;
            $display("wrong value at %0t: %h expected %h", $time, seen, want);
        end
    endtask : chk
    // one Avalon transfer, held until waitrequest is seen low
    task automatic bus(input logic w, input logic [5:0] a, input logic [7:0] d);
        rd <= !w;
        wr <= w;
        adr <= a;
        wdat <= {24'h0, d};
        do begin
            @(negedge sys_clk);
            wq = wait_req;
            got = rdat;
            rsp = resp;
            @(posedge sys_clk);
        end while (wq !== 1'b0);
        rd <= 1'b0;
        wr <= 1'b0;
        @(posedge sys_clk);
    endtask : bus
    task automatic rchk(input logic [5:0] a, input logic [31:0] e);
        repeat (2) @(posedge sys_clk);
        bus(1'b0, a, 8'h00);
        chk(got, e);
    endtask : rchk
    // outputs as {hold, sel, low power, gate, irq}
    task automatic pins(input logic [4:0] e);
        @(negedge sys_clk);
        chk({27'h0, hold, sel, lp, gate, irq}, {27'h0, e});
        @(posedge sys_clk);
    endtask : pins
    task automatic wait_run(input int lim);
        int k;
        k = 0;
        do begin
            @(negedge sys_clk);
            k++;
        end while (sel !== 1'b1 && k < lim);
        chk({31'h0, sel}, 32'h1);
        @(posedge sys_clk);
    endtask : wait_run
    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task automatic t_reset;
        rchk(6'h38, 32'h60);
        rchk(6'h2C, 32'h0);
        pins(5'h08);
        bus(1'b1, 6'h38, 8'h0F);
        rchk(6'h38, 32'h60);
        be <= 4'hE;
        bus(1'b1, 6'h38, 8'h80);
        be <= 4'hF;
        rchk(6'h38, 32'h60);
        pins(5'h08);
        bus(1'b0, 6'h3C, 8'h00);
        chk(got, 32'h0);
        chk({30'h0, rsp}, 32'h2);
    endtask : t_reset
    task automatic t_ident;
        mf <= 8'h01;
        sf <= 8'hFF;
        rchk(6'h2C, 32'h0);
        me <= 8'h01;
        rchk(6'h2C, 32'h01);
        se <= 8'h80;
        rchk(6'h2C, 32'h81);
        se <= 8'h00;
        rchk(6'h2C, 32'h01);
        mf <= 8'h00;
        sf <= 8'h00;
        rchk(6'h2C, 32'h0);
    endtask : t_ident
    task automatic t_stop;
        bus(1'b1, 6'h08, 8'h0F);
        bus(1'b1, 6'h38, 8'h10);
        rchk(6'h38, 32'h70);
        pins(5'h17);
        rchk(6'h0C, 32'h4);
        xp <= 4'h2;
        xe <= 4'h1;
        repeat (20) @(posedge sys_clk);
        pins(5'h17);
        xp <= 4'h3;
        wait_run(40);
        rchk(6'h38, 32'h60);
        xp <= 4'h0;
        rchk(6'h04, 32'h3);
    endtask : t_stop
    task automatic t_irq;
        pins(5'h09);
        bus(1'b1, 6'h08, 8'h00);
        pins(5'h08);
        bus(1'b1, 6'h08, 8'h0F);
        pins(5'h09);
        bus(1'b1, 6'h04, 8'h03);
        pins(5'h08);
    endtask : t_irq
    task automatic t_idle;
        bus(1'b1, 6'h38, 8'h80);
        rchk(6'h38, 32'hE0);
        pins(5'h15);
        rchk(6'h0C, 32'h2);
        sf <= 8'h04;
        se <= 8'h04;
        wait_run(4);
        rchk(6'h38, 32'h60);
        sf <= 8'h00;
        se <= 8'h00;
        bus(1'b1, 6'h38, 8'h80);
        xp <= 4'h1;
        wait_run(8);
        xp <= 4'h0;
        rchk(6'h04, 32'h0C);
    endtask : t_idle
    task automatic t_rst_stop;
        bus(1'b1, 6'h38, 8'h90);
        pins(5'h17);
        rst_b <= 1'b0;
        repeat (2) @(posedge sys_clk);
        rst_b <= 1'b1;
        @(posedge sys_clk);
        rchk(6'h38, 32'h60);
        pins(5'h08);
    endtask : t_rst_stop
    // reset, then the scenarios in turn
    initial begin
        rst_b = 1'b0;
        {rd, wr, adr, wdat, mf, me, sf, se, xp, xe} = '0;
        be = 4'hF;
        repeat (4) @(posedge sys_clk);
        rst_b <= 1'b1;
        @(posedge sys_clk);
        t_reset();
        t_ident();
        t_stop();
        t_irq();
        t_idle();
        t_rst_stop();
        end_of_test();
    end
endmodule : tb_power_mode_and_irq_summary
